// >>> hdl/rscd_pkg.sv
// constants for the run-time settings command decoder
// ****************************************************************
// ****************************************************************
package rscd_pkg;

   // command code
   localparam logic [7:0] CMD_SET_SETTINGS = 8'h60;

   // register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_REPORT = 8'h00; // 16 words, report bytes 0..63
   localparam logic [7:0] OFS_SUBMIT = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h44;
   localparam logic [7:0] OFS_SETTINGS = 8'h48;
   localparam logic [7:0] OFS_PIN_IN = 8'h4C;
   localparam int REPORT_WORDS = 16;

   // report byte positions
   localparam int BYTE_CODE = 0;
   localparam int BYTE_REF = 5;
   localparam int BYTE_IRQ = 6;
   localparam int BYTE_ALTER = 7;
   localparam int BYTE_PIN0 = 8;

   // reference byte fields
   localparam int REF_LOAD_BIT = 7;
   localparam int REF_LVL_HI = 2;
   localparam int REF_LVL_LO = 1;
   localparam int REF_SRC_BIT = 0;

   // interrupt byte fields
   localparam int IRQ_MOD_BIT = 7;
   localparam int IRQ_UPD_RISE = 4;
   localparam int IRQ_RISE_VAL = 3;
   localparam int IRQ_UPD_FALL = 2;
   localparam int IRQ_FALL_VAL = 1;
   localparam int IRQ_CLR_BIT = 0;

   // pin byte fields
   localparam int PIN_VAL_BIT = 4;
   localparam int PIN_DIR_BIT = 3;
   localparam int PIN_FN_HI = 2;
   localparam logic [7:0] ALTER_YES = 8'h01;

   // pin functions
   localparam logic [2:0] FN_GPIO = 3'h0;
   localparam logic [2:0] FN_SUSPEND = 3'h1;
   localparam logic [2:0] FN_RX_LED = 3'h2;

   // reset values of the working settings
   localparam logic [1:0] RST_REF_LVL = 2'h0;
   localparam logic RST_REF_SRC = 1'b0;
   localparam logic [2:0] RST_PIN_FN = FN_GPIO;
   localparam logic RST_PIN_DIR = 1'b1;
   localparam logic RST_PIN_VAL = 1'b0;
   localparam logic RST_RISE_EN = 1'b0;
   localparam logic RST_FALL_EN = 1'b0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {WR_IDLE, WR_RESP} rscd_wr_state_t;

endpackage

// >>> hdl/rscd_edet_if.sv
// control and status path between decoder and edge detector
`timescale 1ns/100ps
interface rscd_edet_if;
   logic upd_rise;
   logic rise_val;
   logic upd_fall;
   logic fall_val;
   logic clr_flag;
   logic rise_en;
   logic fall_en;
   logic flag;

   modport ctrl (output upd_rise, output rise_val, output upd_fall, output fall_val,
      output clr_flag, input rise_en, input fall_en, input flag);
   modport det (input upd_rise, input rise_val, input upd_fall, input fall_val,
      input clr_flag, output rise_en, output fall_en, output flag);
endinterface

// >>> hdl/rscd_edge_det.sv
// edge-interrupt detector with its working settings and sticky flag
`timescale 1ns/100ps
module rscd_edge_det (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // sense pin
   input wire logic sense_in,
   // decoder side
   rscd_edet_if.det ctl
);

   logic prev_q, prev_d;
   logic armed_q, armed_d;
   logic rise_q, rise_d;
   logic fall_q, fall_d;
   logic flag_q, flag_d;
   logic hit;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      prev_d = sense_in;
      armed_d = 1'b1; // no edge is judged against the reset value of prev
      rise_d = ctl.upd_rise ? ctl.rise_val : rise_q;
      fall_d = ctl.upd_fall ? ctl.fall_val : fall_q;
      hit = armed_q & ((rise_q & sense_in & ~prev_q) | (fall_q & ~sense_in & prev_q));
      flag_d = flag_q;
      if (ctl.clr_flag) begin
         flag_d = 1'b0;
      end
      if (hit) begin
         flag_d = 1'b1;
      end
   end

   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
         armed_q <= 1'b0;
         rise_q <= rscd_pkg::RST_RISE_EN;
         fall_q <= rscd_pkg::RST_FALL_EN;
         flag_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         armed_q <= armed_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         flag_q <= flag_d;
      end
   end

   assign ctl.rise_en = rise_q;
   assign ctl.fall_en = fall_q;
   assign ctl.flag = flag_q;

endmodule

// >>> hdl/rscd_top.sv
// run-time settings command decoder with AXI4-Lite register access
`timescale 1ns/100ps
module rscd_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter reference selection
   output logic [1:0] ref_level,
   output logic ref_internal,
   // edge detector
   input wire logic irq_sense_in,
   output logic irq_flag,
   // general pin zero and its alternate sources
   input wire logic general_pin_zero_i,
   output logic general_pin_zero_o,
   output logic general_pin_zero_oe,
   input wire logic suspend_indicator_out,
   input wire logic serial_receive_activity_led
);

   rscd_edet_if edet ();

   // ****************************************************************
   // helpers
   // ****************************************************************
   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // true when an address falls in the report window
   function automatic logic in_report(input logic [ADDR_W-1:0] a);
      return a < ADDR_W'(rscd_pkg::OFS_SUBMIT);
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   logic [31:0] rpt_q [rscd_pkg::REPORT_WORDS];
   logic [31:0] rpt_d [rscd_pkg::REPORT_WORDS];
   rscd_pkg::rscd_wr_state_t wst_q, wst_d;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic do_write, wr_ok;
   logic exec_q, exec_d;
   logic [1:0] ref_lvl_q, ref_lvl_d;
   logic ref_src_q, ref_src_d;
   logic [2:0] pin_fn_q, pin_fn_d;
   logic pin_dir_q, pin_dir_d;
   logic pin_val_q, pin_val_d;
   logic accepted_q, accepted_d;
   logic [7:0] last_code_q, last_code_d;
   logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
   logic [7:0] b_code, b_ref, b_irq, b_alter, b_pin;
   logic cmd_ok, irq_mod;

   // report bytes seen by the decoder
   assign b_code = rpt_q[rscd_pkg::BYTE_CODE / 4][(rscd_pkg::BYTE_CODE % 4)*8 +: 8];
   assign b_ref = rpt_q[rscd_pkg::BYTE_REF / 4][(rscd_pkg::BYTE_REF % 4)*8 +: 8];
   assign b_irq = rpt_q[rscd_pkg::BYTE_IRQ / 4][(rscd_pkg::BYTE_IRQ % 4)*8 +: 8];
   assign b_alter = rpt_q[rscd_pkg::BYTE_ALTER / 4][(rscd_pkg::BYTE_ALTER % 4)*8 +: 8];
   assign b_pin = rpt_q[rscd_pkg::BYTE_PIN0 / 4][(rscd_pkg::BYTE_PIN0 % 4)*8 +: 8];
   assign cmd_ok = exec_q & (b_code == rscd_pkg::CMD_SET_SETTINGS);
   assign irq_mod = cmd_ok & b_irq[rscd_pkg::IRQ_MOD_BIT];

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   // address and data are taken in either order; one write is open at a time
   always_comb begin
      wst_d = wst_q;
      aw_got_d = aw_got_q | (s_axi_awvalid & awready_q);
      w_got_d = w_got_q | (s_axi_wvalid & wready_q);
      waddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : waddr_q;
      wdata_d = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
      wstrb_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb : wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      do_write = 1'b0;
      wr_ok = in_report(waddr_d) || waddr_d == ADDR_W'(rscd_pkg::OFS_SUBMIT);
      case (wst_q)
         rscd_pkg::WR_IDLE: begin
            if (aw_got_d && w_got_d) begin
               do_write = 1'b1;
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               bvalid_d = 1'b1;
               bresp_d = wr_ok ? rscd_pkg::RESP_OKAY : rscd_pkg::RESP_SLVERR;
               wst_d = rscd_pkg::WR_RESP;
            end
         end
         rscd_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               bvalid_d = 1'b0;
               wst_d = rscd_pkg::WR_IDLE;
            end
         end
         default: begin
            wst_d = rscd_pkg::WR_IDLE;
         end
      endcase
      awready_d = (wst_d == rscd_pkg::WR_IDLE) & ~aw_got_d;
      wready_d = (wst_d == rscd_pkg::WR_IDLE) & ~w_got_d;
   end

   // report buffer and submit strobe; execution runs the cycle after the submit write
   always_comb begin
      rpt_d = rpt_q;
      exec_d = 1'b0;
      if (do_write && in_report(waddr_d)) begin
         rpt_d[waddr_d[5:2]] = merge(rpt_q[waddr_d[5:2]], wdata_d, wstrb_d);
      end
      if (do_write && waddr_d == ADDR_W'(rscd_pkg::OFS_SUBMIT) && wstrb_d[0] && wdata_d[0]) begin
         exec_d = 1'b1;
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   always_comb begin
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rresp_d = rscd_pkg::RESP_OKAY;
         rdata_d = 32'h0000_0000;
         if (in_report(s_axi_araddr)) begin
            rdata_d = rpt_q[s_axi_araddr[5:2]];
         end else if (s_axi_araddr == ADDR_W'(rscd_pkg::OFS_SUBMIT)) begin
            rdata_d = 32'h0000_0000; // submit reads as zero
         end else if (s_axi_araddr == ADDR_W'(rscd_pkg::OFS_STATUS)) begin
            rdata_d = {14'h0000, edet.flag, accepted_q, last_code_q, 8'h00};
         end else if (s_axi_araddr == ADDR_W'(rscd_pkg::OFS_SETTINGS)) begin
            rdata_d = {14'h0000, edet.fall_en, edet.rise_en, 3'h0, pin_val_q, pin_dir_q,
               pin_fn_q, 5'h00, ref_lvl_q, ref_src_q};
         end else if (s_axi_araddr == ADDR_W'(rscd_pkg::OFS_PIN_IN)) begin
            rdata_d = {31'h0000_0000, general_pin_zero_i};
         end else begin
            rresp_d = rscd_pkg::RESP_SLVERR; // unmapped
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
   end

   // ****************************************************************
   // command decode
   // ****************************************************************
   // bits not named below are never looked at
   always_comb begin
      ref_lvl_d = ref_lvl_q;
      ref_src_d = ref_src_q;
      pin_fn_d = pin_fn_q;
      pin_dir_d = pin_dir_q;
      pin_val_d = pin_val_q;
      accepted_d = accepted_q;
      last_code_d = last_code_q;
      if (exec_q) begin
         accepted_d = cmd_ok;
         last_code_d = b_code;
      end
      if (cmd_ok && b_ref[rscd_pkg::REF_LOAD_BIT]) begin
         ref_lvl_d = b_ref[rscd_pkg::REF_LVL_HI:rscd_pkg::REF_LVL_LO];
         ref_src_d = b_ref[rscd_pkg::REF_SRC_BIT];
      end
      if (cmd_ok && b_alter == rscd_pkg::ALTER_YES) begin
         pin_val_d = b_pin[rscd_pkg::PIN_VAL_BIT];
         pin_dir_d = b_pin[rscd_pkg::PIN_DIR_BIT];
         // unknown function codes keep the current function
         if (b_pin[rscd_pkg::PIN_FN_HI:0] <= rscd_pkg::FN_RX_LED) begin
            pin_fn_d = b_pin[rscd_pkg::PIN_FN_HI:0];
         end
      end
   end

   // edge detector steering; update and clear strobes gated by the modify enable, edge values passed ungated
   assign edet.upd_rise = irq_mod & b_irq[rscd_pkg::IRQ_UPD_RISE];
   assign edet.rise_val = b_irq[rscd_pkg::IRQ_RISE_VAL];
   assign edet.upd_fall = irq_mod & b_irq[rscd_pkg::IRQ_UPD_FALL];
   assign edet.fall_val = b_irq[rscd_pkg::IRQ_FALL_VAL];
   assign edet.clr_flag = irq_mod & b_irq[rscd_pkg::IRQ_CLR_BIT];

   // ****************************************************************
   // general pin zero drive
   // ****************************************************************
   // direction only matters in GPIO function; alternate functions always drive
   always_comb begin
      case (pin_fn_q)
         rscd_pkg::FN_GPIO: begin
            pin_o_d = pin_val_q;
            pin_oe_d = ~pin_dir_q;
         end
         rscd_pkg::FN_SUSPEND: begin
            pin_o_d = suspend_indicator_out;
            pin_oe_d = 1'b1;
         end
         rscd_pkg::FN_RX_LED: begin
            pin_o_d = serial_receive_activity_led;
            pin_oe_d = 1'b1;
         end
         default: begin
            pin_o_d = 1'b0;
            pin_oe_d = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // working settings fall back to defaults only through reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_q <= rscd_pkg::WR_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= rscd_pkg::RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= rscd_pkg::RESP_OKAY;
         for (int i = 0; i < rscd_pkg::REPORT_WORDS; i++) begin
            rpt_q[i] <= 32'h0000_0000;
         end
         exec_q <= 1'b0;
         ref_lvl_q <= rscd_pkg::RST_REF_LVL;
         ref_src_q <= rscd_pkg::RST_REF_SRC;
         pin_fn_q <= rscd_pkg::RST_PIN_FN;
         pin_dir_q <= rscd_pkg::RST_PIN_DIR;
         pin_val_q <= rscd_pkg::RST_PIN_VAL;
         accepted_q <= 1'b0;
         last_code_q <= 8'h00;
         pin_o_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         wst_q <= wst_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d | (~rvalid_d & ~arready_q & ~rvalid_q); // first ready after reset
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         rpt_q <= rpt_d;
         exec_q <= exec_d;
         ref_lvl_q <= ref_lvl_d;
         ref_src_q <= ref_src_d;
         pin_fn_q <= pin_fn_d;
         pin_dir_q <= pin_dir_d;
         pin_val_q <= pin_val_d;
         accepted_q <= accepted_d;
         last_code_q <= last_code_d;
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // edge detector keeps its own settings and flag
   rscd_edge_det u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .sense_in(irq_sense_in),
      .ctl(edet.det)
   );

   // outputs, all from flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign ref_level = ref_lvl_q;
   assign ref_internal = ref_src_q;
   assign irq_flag = edet.flag;
   assign general_pin_zero_o = pin_o_q;
   assign general_pin_zero_oe = pin_oe_q;

endmodule

// >>> tb/rscd_assertions.sv
// concurrent checks on the ports of the settings decoder
`timescale 1ns/100ps
module rscd_checker #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // settings, flag and pin
   input wire logic [1:0] ref_level,
   input wire logic irq_sense_in,
   input wire logic irq_flag,
   input wire logic general_pin_zero_oe
);
   // ********************
   // checks in the bus clock domain
   // ********************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // settings may move only just after a write response, so stray updates show up
   chk_ref_cause: assert property ($changed(ref_level) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || !$past(aresetn))
      else $error("reference level changed without a command");
   chk_pin_cause: assert property ($changed(general_pin_zero_oe) |->
      $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3) || !$past(aresetn))
      else $error("pin enable changed without a command");
   chk_flag_clear: assert property ($fell(irq_flag) |->
      $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("detection flag dropped without a command");
   chk_flag_set: assert property ($rose(irq_flag) |->
      $past(irq_sense_in) != $past(irq_sense_in, 2))
      else $error("detection flag rose without an input edge");
   // bus answers within a few cycles, and a read-only place is refused
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read data missing");
   chk_ro_refused: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h44
      |-> ##[1:4] s_axi_bvalid && s_axi_bresp == 2'h2)
      else $error("write to status not refused");
   chk_one_write: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while a response is open");
endmodule

bind rscd_top rscd_checker #(.ADDR_W(ADDR_W)) u_checker (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .ref_level(ref_level),
   .irq_sense_in(irq_sense_in),
   .irq_flag(irq_flag),
   .general_pin_zero_oe(general_pin_zero_oe)
);

// >>> tb/rscd_host.sv
// host model: AXI4-Lite master that loads and submits settings reports
`timescale 1ns/100ps
module rscd_host (
   // clock
   input wire logic aclk,
   // write channels
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read channels
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // ********************
   // bus master tasks
   // ********************
   int hang = 0; // waits that ran out of cycles

   // idle bus from time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   // both channels offered together; the leading edge keeps drivers from double assignment
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 64);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 64) hang++;
   endtask

   // one read, data taken at the edge where rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 64);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 64) hang++;
   endtask

   // whole report up to the first pin byte, then submit and let it settle
   task automatic send(input logic [7:0] code, b5, b6, b7, b8);
      logic [1:0] r;
      wr(8'h00, {24'h0, code}, r);
      wr(8'h04, {b7, b6, b5, 8'h00}, r);
      wr(8'h08, {24'h0, b8}, r);
      wr(8'h40, 32'h1, r);
      repeat (4) @(posedge aclk);
   endtask
endmodule

// >>> tb/runtime_settings_command_decoder_test.sv
// self-checking bench for the run-time settings command decoder
`timescale 1ns/100ps
module runtime_settings_command_decoder_test;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, ref_level, r;
   logic ref_internal, irq_sense_in, irq_flag, general_pin_zero_i, general_pin_zero_o;
   logic general_pin_zero_oe, suspend_indicator_out, serial_receive_activity_led;
   int error_cnt = 0;
   int n_tests = 0;

   // ********************
   // clock, pin wire and instances
   // ********************
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // pin has a pull-up, so a released pin reads high
   assign general_pin_zero_i = general_pin_zero_oe ? general_pin_zero_o : 1'b1;
   rscd_host host (.*);
   rscd_top dut (.*);

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run();
      error_cnt += host.hang;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // sense input edge, flag judged once the detector has sampled it
   task automatic sense(input logic v, input logic exp, input string what);
      @(posedge aclk);
      irq_sense_in <= v;
      repeat (3) @(posedge aclk);
      chk(what, exp, irq_flag);
   endtask

   // alternate sources change; pin enable and level compared
   task automatic alt(input logic s, input logic l, input logic [1:0] exp, input string what);
      @(posedge aclk);
      suspend_indicator_out <= s;
      serial_receive_activity_led <= l;
      repeat (3) @(posedge aclk);
      chk(what, exp, {general_pin_zero_oe, general_pin_zero_o});
   endtask

   task automatic t_reset();
      @(posedge aclk);
      chk("ref_level", 0, ref_level);
      chk("pin_oe", 0, general_pin_zero_oe);
      host.rd(8'h48, d, r);
      chk("settings", 32'h800, d);
   endtask

   // every level and source, don't-care bits set; then loads that must not act
   task automatic t_ref();
      for (int i = 0; i < 8; i++) begin
         host.send(8'h60, 8'hF8 | 8'(i), 8'h00, 8'h00, 8'h00);
         chk("ref_level", i[2:1], ref_level);
         chk("ref_internal", i[0], ref_internal);
      end
      host.send(8'h60, 8'h7E, 8'h00, 8'h00, 8'h00);
      chk("ref_hold", 3'h7, {ref_level, ref_internal});
      host.send(8'h61, 8'h80, 8'h00, 8'h00, 8'h00);
      chk("ref_wrong_code", 3'h7, {ref_level, ref_internal});
      host.rd(8'h44, d, r);
      chk("status", 9'h061, d[16:8]);
   endtask

   task automatic t_bus();
      host.rd(8'h50, d, r);
      chk("unmapped_resp", 2'h2, r);
      chk("unmapped_data", 0, d);
      host.wr(8'h44, 32'hFFFFFFFF, r);
      chk("ro_resp", 2'h2, r);
      host.rd(8'h04, d, r);
      chk("report_word", 32'h00008000, d);
   endtask

   task automatic t_irq();
      host.send(8'h60, 8'h00, 8'hF8, 8'h00, 8'h00);
      sense(1'b1, 1'b1, "rise_sets");
      host.send(8'h60, 8'h00, 8'h81, 8'h00, 8'h00);
      chk("flag_cleared", 0, irq_flag);
      sense(1'b0, 1'b0, "fall_off");
      sense(1'b1, 1'b1, "rise_again");
      host.send(8'h60, 8'h00, 8'h7F, 8'h00, 8'h00);
      chk("mod_off", 1, irq_flag);
      host.send(8'h60, 8'h00, 8'h80, 8'h00, 8'h00);
      chk("clr_zero", 1, irq_flag);
      host.send(8'h60, 8'h00, 8'h87, 8'h00, 8'h00);
      chk("fall_clr", 0, irq_flag);
      host.rd(8'h48, d, r);
      chk("edge_en", 2'h3, d[17:16]);
      sense(1'b0, 1'b1, "fall_sets");
      host.send(8'h60, 8'h00, 8'h95, 8'h00, 8'h00);
      sense(1'b1, 1'b0, "both_off");
   endtask

   task automatic t_pin();
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'hF0);
      chk("gpio_out", 2'h3, {general_pin_zero_oe, general_pin_zero_o});
      host.send(8'h60, 8'h00, 8'h00, 8'h00, 8'h08);
      chk("alter_off", 2'h3, {general_pin_zero_oe, general_pin_zero_o});
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'h00);
      chk("gpio_low", 2'h2, {general_pin_zero_oe, general_pin_zero_o});
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'h18);
      chk("gpio_in", 0, general_pin_zero_oe);
      host.rd(8'h4C, d, r);
      chk("pin_level", 1, d[0]);
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'h09);
      alt(1'b1, 1'b0, 2'h3, "suspend_hi");
      alt(1'b0, 1'b1, 2'h2, "suspend_lo");
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'h0A);
      alt(1'b0, 1'b1, 2'h3, "led_hi");
      alt(1'b1, 1'b0, 2'h2, "led_lo");
      host.send(8'h60, 8'h00, 8'h00, 8'h01, 8'h13);
      host.rd(8'h48, d, r);
      chk("fn_kept", 3'h2, d[10:8]);
   endtask

   // mid-run reset must bring every working setting back to its default
   task automatic t_rerun();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
   endtask

   // main sequence
   initial begin
      aresetn = 1'b0;
      {irq_sense_in, suspend_indicator_out, serial_receive_activity_led} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_ref();
      t_bus();
      t_irq();
      t_pin();
      t_rerun();
      complete_run();
   end
endmodule
